// ### logic/door_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module door_ctrl import door_ctrl_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Driver panel and vehicle
  input wire logic btn_rel_right,
  input wire logic btn_open_right,
  input wire logic btn_rel_left,
  input wire logic btn_open_left,
  input wire logic btn_close,
  input wire logic btn_unlock_left,
  input wire logic cab_active,
  input wire logic speed_low,
  input wire logic loop_bypass,
  // Per-door sensors and buttons
  input wire logic [NDOOR-1:0] pax_btn,
  input wire logic [NDOOR-1:0] obstacle,
  input wire logic [NDOOR-1:0] closed_locked,
  input wire logic [NDOOR-1:0] fully_open,
  input wire logic [NDOOR-1:0] emerg_handle,
  input wire logic [NDOOR-1:0] first_ctl,
  // Door actuators and indicators
  output logic [NDOOR-1:0] door_open_cmd,
  output logic [NDOOR-1:0] door_close_cmd,
  output logic [NDOOR-1:0] btn_lamp,
  output logic [NDOOR-1:0] isol_ind,
  output logic warn_pre,
  output logic warn_close,
  output logic loop_closed,
  output logic traction_en,
  output logic emerg_ind,
  output logic fail_ind
);

  state_t q;
  state_t n;
  logic [PIN_W-1:0] raw;

  assign raw = {first_ctl, emerg_handle, fully_open, closed_locked,
                obstacle, pax_btn, loop_bypass, speed_low, cab_active,
                btn_unlock_left, btn_close, btn_open_left, btn_rel_left,
                btn_open_right, btn_rel_right};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign door_open_cmd = q.o.open_cmd;
  assign door_close_cmd = q.o.close_cmd;
  assign btn_lamp = q.o.btn_lamp;
  assign isol_ind = q.o.isol_ind;
  assign warn_pre = q.o.warn_pre;
  assign warn_close = q.o.warn_close;
  assign loop_closed = q.o.loop_closed;
  assign traction_en = q.o.traction_en;
  assign emerg_ind = q.o.emerg_ind;
  assign fail_ind = q.o.fail_ind;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [PIN_W-1:0] press;
    logic tick;
    logic slow;
    logic cab;
    logic close_go;
    logic open_r;
    logic open_l;
    logic force_close;
    logic [NDOOR-1:0] side_open;
    logic [NDOOR-1:0] side_rel;
    logic [NDOOR-1:0] want_open;
    logic [NDOOR-1:0] settled;
    logic [17:0] lim;
    logic [17:0] dwell_ms;
    logic addr_ok;
    n = q;
    press = '0;
    tick = 1'b0;
    close_go = 1'b0;
    open_r = 1'b0;
    open_l = 1'b0;
    side_open = '0;
    side_rel = '0;
    want_open = '0;
    settled = '0;
    lim = '0;
    addr_ok = 1'b0;
    dwell_ms = 18'(q.dwell_s) * 18'(MS_PER_S);

    // Three-stage sampling; a level is accepted once stages 2 and 3 agree
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < PIN_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.pin[i] = q.s3[i];
      end
    end
    press = n.pin & ~q.pin;
    slow = q.pin[P_SLOW];
    cab = q.pin[P_CAB];

    // Millisecond tick; keeps long timers narrow
    if (q.tick_cnt >= 32'(TICK_LEN - 1)) begin
      n.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 32'd1;
    end
    if (tick) begin
      if (q.blink_cnt >= T_BLINK_MS - 9'd1) begin
        n.blink_cnt = '0;
        n.blink = ~q.blink;
      end else begin
        n.blink_cnt = q.blink_cnt + 9'd1;
      end
    end

    // ---------------------------------------------------------------
    // Driver commands; release is only dropped by close, not by cab
    // ---------------------------------------------------------------
    if (cab) begin
      if (press[P_UNLOCK]) begin
        n.unlock_l = 1'b1;
      end
      if (slow && (press[P_REL_R] || press[P_OPEN_R])) begin
        n.rel_r = 1'b1;
        open_r = press[P_OPEN_R];
      end
      if (slow && q.unlock_l &&
          (press[P_REL_L] || press[P_OPEN_L])) begin
        n.rel_l = 1'b1;
        open_l = press[P_OPEN_L];
      end
      if (press[P_CLOSE]) begin
        n.rel_r = 1'b0;
        n.rel_l = 1'b0;
        n.unlock_l = 1'b0;
        n.prewarn = 1'b1;
        n.pw_cnt = '0;
      end
    end

    // Pre-warning runs to completion before the driver close reaches any open door
    if (q.prewarn && tick) begin
      if (q.pw_cnt >= T_PREWARN_MS - 18'd1) begin
        n.prewarn = 1'b0;
        close_go = 1'b1;
      end else begin
        n.pw_cnt = q.pw_cnt + 18'd1;
      end
    end

    side_open = (open_r ? RIGHT_MASK : '0) |
                (open_l ? ~RIGHT_MASK : '0);
    side_rel = (q.rel_r ? RIGHT_MASK : '0) | (q.rel_l ? ~RIGHT_MASK : '0);
    force_close = q.pin[P_BYP] && !slow;

    // ---------------------------------------------------------------
    // Bus: address phase latched, write lands in data phase
    // ---------------------------------------------------------------
    if (q.dp_wr) begin
      case (q.dp_addr)
        A_CFG: begin
          n.retry_lim = hwdata[3:0];
          n.dwell_s = hwdata[CFG_DWELL_LSB +: 8];
        end
        A_ISOL: n.isol = hwdata[NDOOR-1:0];
        A_FAULT: n.fault = q.fault & ~hwdata[NDOOR-1:0];
        A_FAIL: n.fail = q.fail & ~hwdata[NDOOR-1:0];
        default: ;
      endcase
    end
    n.dp_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      addr_ok = (haddr[31:5] == '0) && (hsize == HSIZE_WORD);
      n.dp_wr = hwrite && addr_ok;
      n.dp_addr = haddr[4:2];
      n.rdata = '0;
      if (!hwrite && addr_ok) begin
        case (haddr[4:2])
          A_CFG: begin
            n.rdata[3:0] = q.retry_lim;
            n.rdata[CFG_DWELL_LSB +: 8] = q.dwell_s;
          end
          A_ISOL: n.rdata[NDOOR-1:0] = q.isol;
          A_FAULT: n.rdata[NDOOR-1:0] = q.fault;
          A_FAIL: n.rdata[NDOOR-1:0] = q.fail;
          A_STATUS: n.rdata = {4'h0, q.pin[P_EMERG +: NDOOR], 7'h0,
                               q.pin[P_BYP], slow, q.o.warn_close,
                               q.o.warn_pre, q.unlock_l, q.rel_l,
                               q.rel_r, q.o.traction_en,
                               q.o.loop_closed};
          A_DOORS: begin
            for (int i = 0; i < NDOOR; i++) begin
              n.rdata[i] = (q.door[i].st == D_CLOSED);
              n.rdata[HI_LSB + i] = (q.door[i].st == D_OPEN);
            end
          end
          default: ;
        endcase
      end
    end

    // ---------------------------------------------------------------
    // Doors; hardware sets after bus clears so a set is never lost
    // ---------------------------------------------------------------
    for (int i = 0; i < NDOOR; i++) begin
      lim = FIRST_MASK[i] ? T_SINGLE_MS : T_DOUBLE_MS;
      want_open[i] = side_open[i] ||
                     (side_rel[i] && press[P_PB + i]) ||
                     (FIRST_MASK[i] && press[P_FIRST + i]) ||
                     q.pin[P_EMERG + i];
      if (tick && q.door[i].tmr != '1) begin
        n.door[i].tmr = q.door[i].tmr + 18'd1;
      end
      case (q.door[i].st)
        D_CLOSED: begin
          n.door[i].retries = '0;
          if (q.door[i].reopen && !q.fault[i] && !q.isol[i] && slow) begin
            n.door[i].st = D_OPENING;
            n.door[i].tmr = '0;
            n.door[i].reopen = 1'b0;
            n.door[i].reclose = 1'b1;
          end else if (want_open[i] && slow &&
                       !q.fault[i] && !q.isol[i]) begin
            n.door[i].st = D_OPENING;
            n.door[i].tmr = '0;
            n.door[i].pax = !side_open[i];
            n.door[i].reclose = 1'b0;
          end
        end
        D_OPENING: begin
          if (q.fault[i] || q.isol[i] || force_close) begin
            n.door[i].st = D_CLOSING;
            n.door[i].tmr = '0;
          // Edge only: filtered level outlasts a reversal by a few clocks
          end else if (press[P_OBS + i]) begin
            n.door[i].st = D_CLOSING;
            n.door[i].tmr = '0;
            if (q.door[i].retries < q.retry_lim) begin
              n.door[i].retries = q.door[i].retries + 4'd1;
              n.door[i].reopen = 1'b1;
            end else begin
              n.fail[i] = 1'b1;
            end
          end else if (q.pin[P_FOPEN + i]) begin
            n.door[i].st = D_OPEN;
            n.door[i].tmr = '0;
          end else if (q.door[i].tmr >= lim) begin
            n.fault[i] = 1'b1;
            n.door[i].st = D_CLOSING;
            n.door[i].tmr = '0;
          end
        end
        D_OPEN: begin
          if (close_go || q.fault[i] || q.isol[i] || force_close ||
              q.door[i].reclose ||
              (q.door[i].pax && q.door[i].tmr >= dwell_ms)) begin
            n.door[i].st = D_CLOSING;
            n.door[i].tmr = '0;
            n.door[i].reclose = 1'b0;
            n.door[i].pax = 1'b0;
          end
        end
        D_CLOSING: begin
          if (q.pin[P_OBS + i] && !q.isol[i] && !q.fault[i]) begin
            n.door[i].tmr = '0;
            n.door[i].st = D_OPEN;
            n.door[i].reopen = 1'b0;
            if (q.door[i].retries < q.retry_lim) begin
              n.door[i].st = D_OPENING;
              n.door[i].retries = q.door[i].retries + 4'd1;
              n.door[i].reclose = 1'b1;
            end else begin
              n.fail[i] = 1'b1;
              n.door[i].reclose = 1'b0;
              n.door[i].pax = 1'b0;
            end
          end else if (q.pin[P_LOCKED + i]) begin
            n.door[i].st = D_CLOSED;
          end else if (q.door[i].tmr >= lim) begin
            n.fault[i] = 1'b1;
          end
        end
        default: n.door[i].st = D_CLOSING;
      endcase
      settled[i] = (n.door[i].st == D_CLOSED) && q.pin[P_LOCKED + i];
    end

    // ---------------------------------------------------------------
    // Outputs, registered from the next state
    // ---------------------------------------------------------------
    for (int i = 0; i < NDOOR; i++) begin
      n.o.open_cmd[i] = (n.door[i].st == D_OPENING) ||
                        (n.door[i].st == D_OPEN);
      n.o.close_cmd[i] = (n.door[i].st == D_CLOSING) ||
                         (n.door[i].st == D_CLOSED);
    end
    n.o.btn_lamp = (n.rel_r ? RIGHT_MASK : '0) |
                   (n.rel_l ? ~RIGHT_MASK : '0);
    n.o.btn_lamp = n.blink ? n.o.btn_lamp : '0;
    n.o.isol_ind = n.isol;
    n.o.warn_close = 1'b0;
    for (int i = 0; i < NDOOR; i++) begin
      if (n.door[i].st == D_CLOSING) begin
        n.o.warn_close = 1'b1;
      end
    end
    // Closing tone takes over once any door is closing
    n.o.warn_pre = n.prewarn && !n.o.warn_close;
    n.o.loop_closed = &settled;
    n.o.traction_en = (n.o.loop_closed || q.pin[P_BYP]) &&
                      !(|(FIRST_MASK & q.pin[P_FIRST +: NDOOR]));
    n.o.emerg_ind = |q.pin[P_EMERG +: NDOOR];
    n.o.fail_ind = |n.fail;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.retry_lim <= RETRY_RST;
      q.dwell_s <= DWELL_RST;
      for (int i = 0; i < NDOOR; i++) begin
        q.door[i].st <= D_CLOSED;
      end
      q.o.close_cmd <= '1;
    end else begin
      q <= n;
    end
  end

endmodule : door_ctrl
`default_nettype wire

// ### pkg/door_ctrl_pkg.sv
// Function
// - All doors on one side get open and close commands in the same cycle.
// - Driver commands: release right, open right, release left, open left, close.
// - Left release or open ignored until the left unlock button was pressed.
// - No door opens unless the vehicle is below the speed threshold; an obstacle while closing reopens the door at any speed.
// - Moves over 3.5 s (double) or 4 s (single) count as a fault.
// - A faulted door is driven closed and ignores open requests.
// - Door states are always visible and faults are latched for diagnostics.
// - Driver close sounds a 3 s pre-warning before any door closes.
// - During closing the warning uses a second, different tone.
// - Warnings are silent outside pre-warning and closing.
// - When released, passenger buttons open their door; button lamps flash.
// - Passenger-opened door recloses after the dwell time, default 30 s.
// - Cab going inactive does not clear the released state.
// - Obstacle while closing reopens and retries, default three, then stays open.
// - Retries exhausted raises a failure notification to the driver.
// - Obstacle during opening is handled in the same reversing way.
// - Door loop closed only with every door closed and locked.
// - Sealed bypass overrides the traction inhibit; loop status is indicated.
// - With bypass on, doors are closed once speed exceeds the threshold.
// - Isolated door is held closed, ignores commands, and is indicated.
// - Emergency release is indicated; the door opens only once stopped.
// - First doors open individually, only when slow, and cut traction.
package door_ctrl_pkg;

  localparam int NDOOR = 12;
  localparam logic [NDOOR-1:0] FIRST_MASK = 12'h861;
  localparam logic [NDOOR-1:0] RIGHT_MASK = 12'h03f;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [17:0] T_DOUBLE_MS = 18'd3500;
  localparam logic [17:0] T_SINGLE_MS = 18'd4000;
  localparam logic [17:0] T_PREWARN_MS = 18'd3000;
  localparam logic [8:0] T_BLINK_MS = 9'd500;
  localparam logic [9:0] MS_PER_S = 10'd1000;

  // ---------------------------------------------------------------
  // Pin vector layout
  // ---------------------------------------------------------------
  localparam int P_REL_R = 0;
  localparam int P_OPEN_R = 1;
  localparam int P_REL_L = 2;
  localparam int P_OPEN_L = 3;
  localparam int P_CLOSE = 4;
  localparam int P_UNLOCK = 5;
  localparam int P_CAB = 6;
  localparam int P_SLOW = 7;
  localparam int P_BYP = 8;
  localparam int P_PB = 9;
  localparam int P_OBS = 21;
  localparam int P_LOCKED = 33;
  localparam int P_FOPEN = 45;
  localparam int P_EMERG = 57;
  localparam int P_FIRST = 69;
  localparam int PIN_W = 81;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  localparam logic [2:0] A_CFG = 3'h0;
  localparam logic [2:0] A_ISOL = 3'h1;
  localparam logic [2:0] A_FAULT = 3'h2;
  localparam logic [2:0] A_FAIL = 3'h3;
  localparam logic [2:0] A_STATUS = 3'h4;
  localparam logic [2:0] A_DOORS = 3'h5;
  localparam logic [3:0] RETRY_RST = 4'h3;
  localparam logic [7:0] DWELL_RST = 8'h1e;
  localparam int CFG_DWELL_LSB = 8;
  localparam int HI_LSB = 16;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    D_CLOSED = 2'b00,
    D_OPENING = 2'b01,
    D_OPEN = 2'b10,
    D_CLOSING = 2'b11
  } dstate_t;

  typedef struct packed {
    dstate_t st;
    logic [17:0] tmr;
    logic [3:0] retries;
    logic reclose;
    logic reopen;
    logic pax;
  } door_t;

  typedef struct packed {
    logic [NDOOR-1:0] open_cmd;
    logic [NDOOR-1:0] close_cmd;
    logic [NDOOR-1:0] btn_lamp;
    logic [NDOOR-1:0] isol_ind;
    logic warn_pre;
    logic warn_close;
    logic loop_closed;
    logic traction_en;
    logic emerg_ind;
    logic fail_ind;
  } outs_t;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pin;
    logic [31:0] tick_cnt;
    logic [8:0] blink_cnt;
    logic blink;
    logic rel_r;
    logic rel_l;
    logic unlock_l;
    logic prewarn;
    logic [17:0] pw_cnt;
    door_t [NDOOR-1:0] door;
    logic [3:0] retry_lim;
    logic [7:0] dwell_s;
    logic [NDOOR-1:0] isol;
    logic [NDOOR-1:0] fault;
    logic [NDOOR-1:0] fail;
    logic dp_wr;
    logic [2:0] dp_addr;
    logic [31:0] rdata;
    outs_t o;
  } state_t;

endpackage : door_ctrl_pkg

// ### verif/door_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module door_ctrl_sva import door_ctrl_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Vehicle and door inputs
  input wire logic speed_low,
  input wire logic loop_bypass,
  input wire logic [NDOOR-1:0] emerg_handle,
  input wire logic [NDOOR-1:0] first_ctl,
  // Controller outputs
  input wire logic [NDOOR-1:0] door_open_cmd,
  input wire logic [NDOOR-1:0] door_close_cmd,
  input wire logic [NDOOR-1:0] isol_ind,
  input wire logic warn_pre,
  input wire logic warn_close,
  input wire logic loop_closed,
  input wire logic traction_en,
  input wire logic emerg_ind
);
  localparam int PW_LO = 2999 * TICK_LEN;
  localparam int PW_HI = 3000 * TICK_LEN + 2;
  logic [31:0] pw_q;
  logic [7:0] spd_q;
  logic [7:0] byp_q;
  // History spans the input filter delay
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pw_q <= '0;
      spd_q <= '0;
      byp_q <= '0;
    end else begin
      pw_q <= warn_pre ? pw_q + 32'h1 : 32'h0;
      spd_q <= {spd_q[6:0], speed_low};
      byp_q <= {byp_q[6:0], loop_bypass};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  warn_excl_a: assert property (!(warn_pre && warn_close))
    else $error("both warning tones on");
  prewarn_len_a: assert property (
    $fell(warn_pre) |-> pw_q >= PW_LO && pw_q <= PW_HI)
    else $error("pre-warning length wrong");
  close_tone_a: assert property (
    $rose(warn_close) |-> (door_close_cmd & ~$past(door_close_cmd)) != '0)
    else $error("closing tone with no door closing");
  loop_doors_a: assert property (
    loop_closed |-> door_close_cmd == '1)
    else $error("loop closed with a door not closed");
  traction_src_a: assert property (
    traction_en && !loop_closed |-> (|byp_q) || $past(loop_closed))
    else $error("traction with open loop and no bypass");
  first_cut_a: assert property (
    ((first_ctl & FIRST_MASK) != '0) [*8] |=> !traction_en)
    else $error("first door control did not cut traction");
  slow_open_a: assert property (
    (door_open_cmd & ~$past(door_open_cmd)) != '0 |-> |spd_q)
    else $error("door opened above speed threshold");
  isol_hold_a: assert property (
    (isol_ind & $past(isol_ind) & door_open_cmd) == '0)
    else $error("isolated door commanded open");
  emerg_show_a: assert property (
    (|emerg_handle) [*8] |-> emerg_ind)
    else $error("emergency handle not indicated");
  cover property ($fell(warn_pre));
  cover property ($rose(emerg_ind));
  cover property (traction_en && !loop_closed);
endmodule : door_ctrl_sva
bind door_ctrl door_ctrl_sva #(.TICK_LEN(TICK_LEN)) sva_i (
  .clk_sys,
  .nrst,
  .speed_low,
  .loop_bypass,
  .emerg_handle,
  .first_ctl,
  .door_open_cmd,
  .door_close_cmd,
  .isol_ind,
  .warn_pre,
  .warn_close,
  .loop_closed,
  .traction_en,
  .emerg_ind
);
`default_nettype wire

// ### verif/door_model.sv
`timescale 1ns/1ps
`default_nettype none
module door_model import door_ctrl_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Commands from the controller
  input wire logic [NDOOR-1:0] open_cmd,
  input wire logic [NDOOR-1:0] close_cmd,
  // Scenario controls
  input wire logic [NDOOR-1:0] stuck,
  input wire logic [NDOOR-1:0] slow,
  input wire logic [NDOOR-1:0] jam,
  // Door sensors
  output logic [NDOOR-1:0] fully_open,
  output logic [NDOOR-1:0] closed_locked,
  output logic [NDOOR-1:0] obstacle
);
  int cnt_q [NDOOR];
  // ---------------------------------------------
  // Leaf travel
  // ---------------------------------------------
  // Travel count survives a reversal, so a reopened leaf arrives early
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fully_open <= '0;
      closed_locked <= '1;
      for (int i = 0; i < NDOOR; i++) cnt_q[i] <= 0;
    end else begin
      for (int i = 0; i < NDOOR; i++) begin
        if (open_cmd[i] ? fully_open[i] : closed_locked[i]) begin
          cnt_q[i] <= 0;
        end else begin
          fully_open[i] <= 1'b0;
          closed_locked[i] <= 1'b0;
          cnt_q[i] <= cnt_q[i] + 1;
          if (!stuck[i] && cnt_q[i] >= (slow[i] ? 200 : 20)) begin
            fully_open[i] <= open_cmd[i];
            closed_locked[i] <= !open_cmd[i];
          end
        end
      end
    end
  end
  // A jammed leaf trips the edge sensor only while closing
  assign obstacle = jam & close_cmd & ~closed_locked;
endmodule : door_model
`default_nettype wire

// ### verif/tram_door_interlock_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tram_door_interlock_controller_tb import door_ctrl_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst, hsel, hwrite, hreadyout, hresp, cab_active, speed_low;
  logic loop_bypass, warn_pre, warn_close, loop_closed, traction_en;
  logic emerg_ind, fail_ind;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] btn;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [NDOOR-1:0] pax_btn, obstacle, closed_locked, fully_open, jam;
  logic [NDOOR-1:0] emerg_handle, first_ctl, stuck, slow, isol_ind;
  logic [NDOOR-1:0] door_open_cmd, door_close_cmd, btn_lamp;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  door_ctrl #(.TICK_LEN(2)) dut (
    .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .btn_rel_right(btn[P_REL_R]),
    .btn_open_right(btn[P_OPEN_R]),
    .btn_rel_left(btn[P_REL_L]),
    .btn_open_left(btn[P_OPEN_L]),
    .btn_close(btn[P_CLOSE]),
    .btn_unlock_left(btn[P_UNLOCK]),
    .cab_active, .speed_low, .loop_bypass, .pax_btn, .obstacle,
    .closed_locked, .fully_open, .emerg_handle, .first_ctl,
    .door_open_cmd, .door_close_cmd, .btn_lamp, .isol_ind, .warn_pre,
    .warn_close, .loop_closed, .traction_en, .emerg_ind, .fail_ind
  );
  door_model act (
    .clk_sys, .nrst, .open_cmd(door_open_cmd),
    .close_cmd(door_close_cmd), .stuck, .slow, .jam, .fully_open,
    .closed_locked, .obstacle
  );

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] cur(input int sel);
    case (sel)
      0: return 32'(door_open_cmd);
      1: return 32'(door_close_cmd);
      2: return 32'(btn_lamp);
      3: return {30'h0, warn_close, warn_pre};
      4: return {30'h0, traction_en, loop_closed};
      5: return {30'h0, fail_ind, emerg_ind};
      default: return 32'(isol_ind);
    endcase
  endfunction : cur

  // Waits at most lim cycles for the value, then compares
  task automatic want(input int sel, input logic [31:0] exp, input int lim);
    int n;
    n = 0;
    while (cur(sel) !== exp && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(cur(sel), exp);
  endtask : want

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask : bus

  // Held past the input filter so the press edge is seen
  task automatic press(input logic [5:0] b, input logic [NDOOR-1:0] p);
    @(posedge clk_sys);
    btn <= b;
    pax_btn <= p;
    repeat (8) @(posedge clk_sys);
    btn <= '0;
    pax_btn <= '0;
    repeat (8) @(posedge clk_sys);
  endtask : press

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    {nrst, hsel, hwrite, htrans, hsize, haddr, hwdata, btn} = '0;
    {cab_active, speed_low, loop_bypass, pax_btn, emerg_handle} = '0;
    {first_ctl, stuck, jam} = '0;
    slow = 12'h0c0;
    repeat (4) @(posedge clk_sys);
    want(1, 32'hfff, 0);
    nrst <= 1'b1;
    bus(1'b0, 32'h0, 32'h0);
    chk(rd_val, 32'h1e03);
    bus(1'b1, 32'h0, 32'h0103);
    bus(1'b0, 32'h20, 32'h0);
    chk(rd_val, 32'h0);
    cab_active <= 1'b1;
    speed_low <= 1'b1;
    press(6'h08, '0);
    want(0, 32'h0, 0);
    press(6'h02, '0);
    want(0, 32'(RIGHT_MASK), 10);
    want(4, 32'h0, 0);
    press(6'h20, '0);
    press(6'h08, '0);
    want(0, 32'hfff, 10);
    press(6'h10, '0);
    want(3, 32'h1, 10);
    repeat (5000) @(posedge clk_sys);
    want(1, 32'h0, 0);
    want(3, 32'h2, 1200);
    want(4, 32'h3, 400);
    want(3, 32'h0, 0);
    speed_low <= 1'b0;
    press(6'h02, '0);
    want(0, 32'h0, 0);
    speed_low <= 1'b1;
    press(6'h01, '0);
    cab_active <= 1'b0;
    want(2, 32'(RIGHT_MASK), 1200);
    press(6'h00, 12'h002);
    want(0, 32'h2, 20);
    want(1, 32'hfff, 2600);
    press(6'h00, 12'h004);
    want(0, 32'h4, 20);
    jam <= 12'h004;
    want(5, 32'h2, 4000);
    want(0, 32'h4, 0);
    bus(1'b0, 32'hc, 32'h0);
    chk(rd_val, 32'h4);
    bus(1'b1, 32'hc, 32'h4);
    want(5, 32'h0, 4);
    {jam, stuck} <= {12'h0, 12'h001};
    cab_active <= 1'b1;
    press(6'h02, '0);
    want(0, 32'h03e, 8400);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd_val, 32'h1);
    stuck <= '0;
    repeat (8) @(posedge clk_sys);
    press(6'h02, '0);
    want(0, 32'h03e, 0);
    bus(1'b0, 32'h14, 32'h0);
    chk(rd_val, 32'h003e0fc1);
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd_val, 32'h0);
    press(6'h10, '0);
    want(4, 32'h3, 6800);
    bus(1'b1, 32'h4, 32'h8);
    press(6'h02, '0);
    want(0, 32'h037, 10);
    want(6, 32'h8, 0);
    loop_bypass <= 1'b1;
    want(4, 32'h2, 10);
    speed_low <= 1'b0;
    want(1, 32'hfff, 400);
    emerg_handle <= 12'h010;
    want(5, 32'h1, 10);
    want(0, 32'h0, 0);
    speed_low <= 1'b1;
    want(0, 32'h010, 60);
    emerg_handle <= '0;
    first_ctl <= 12'h020;
    want(0, 32'h030, 20);
    want(4, 32'h0, 10);
    close_out();
  end
endmodule : tram_door_interlock_controller_tb
`default_nettype wire
